//--- include/rdcfg_map.svh
// Register offsets, reset values, field positions and timing counts
`ifndef RDCFG_MAP_SVH
`define RDCFG_MAP_SVH

`define RDCFG_OFS_SPARE_A        8'h09
`define RDCFG_OFS_PRESENCE       8'h0A
`define RDCFG_OFS_SPARE_B        8'h0B
`define RDCFG_OFS_SPARE_C        8'h0C
`define RDCFG_OFS_SPARE_D        8'h0D
`define RDCFG_OFS_TERMINATION    8'h0E
`define RDCFG_OFS_BOOST          8'h0F
`define RDCFG_OFS_OUTPUT_CTRL    8'h10

`define RDCFG_RST_SPARE_A        8'h00
`define RDCFG_RST_PRESENCE       8'h00
`define RDCFG_RST_SPARE_B        8'h70
`define RDCFG_RST_SPARE_C        8'h00
`define RDCFG_RST_SPARE_D        8'h00
`define RDCFG_RST_TERMINATION    8'h00
`define RDCFG_RST_BOOST          8'h2F
`define RDCFG_RST_OUTPUT_CTRL    8'hAD
`define RDCFG_RST_UNMAPPED       8'h00

`define RDCFG_FES_MSB            3
`define RDCFG_FES_LSB            2
`define RDCFG_SHORT_PROT_BIT     7
`define RDCFG_SWING_MSB          2
`define RDCFG_SWING_LSB          0

`define RDCFG_CLK_HZ             25000000
`define RDCFG_PROBE_PERIOD_MS    12
`define RDCFG_PROBE_PERIOD_CYC   ((`RDCFG_PROBE_PERIOD_MS * `RDCFG_CLK_HZ) / 1000)
`define RDCFG_PROBE_ATTEMPTS     50

`define RDCFG_DEV_ADDR           7'h5A

`endif

//--- include/rdcfg_pkg.sv
// Types shared by the lane configuration register bank
package rdcfg_pkg;

    typedef enum logic [1:0] {
        FES_HIZ          = 2'b00,
        FES_AUTO_LIMITED = 2'b01,
        FES_AUTO_ENDLESS = 2'b10,
        FES_TERM_50      = 2'b11
    } rdcfg_fes_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0000,
        ST_ADDR  = 4'b0001,
        ST_AACK  = 4'b0010,
        ST_CMD   = 4'b0011,
        ST_CACK  = 4'b0100,
        ST_WDATA = 4'b0101,
        ST_WACK  = 4'b0110,
        ST_RDATA = 4'b0111,
        ST_RACK  = 4'b1000
    } rdcfg_state_t;

    typedef logic [2:0] rdcfg_swing_t;

endpackage : rdcfg_pkg

//--- include/rdcfg_sense_if.sv
// Link between the register bank and the far-end sense engine
`timescale 1ns/1ns
interface rdcfg_sense_if;
    rdcfg_pkg::rdcfg_fes_t code;
    logic                  rx_present;
    logic                  term_50;
    logic                  probe;

    modport ctrl   (output code, output rx_present, input term_50, input probe);
    modport engine (input code, input rx_present, output term_50, output probe);
endinterface : rdcfg_sense_if

//--- logic/rdcfg_sense.sv
// Far-end receiver sense engine for lane b0
`timescale 1ns/1ns
`include "rdcfg_map.svh"
module rdcfg_sense #(
    parameter int unsigned PROBE_PERIOD_CYC = `RDCFG_PROBE_PERIOD_CYC,
    parameter int unsigned PROBE_ATTEMPTS   = `RDCFG_PROBE_ATTEMPTS
) (
    input  wire logic      clk,
    input  wire logic      rst,
    rdcfg_sense_if.engine  sif
);
    import rdcfg_pkg::*;

    localparam int TW = $clog2(PROBE_PERIOD_CYC + 1);
    localparam int AW = $clog2(PROBE_ATTEMPTS + 1);
    localparam logic [TW-1:0] LAST_TICK = TW'(PROBE_PERIOD_CYC - 1);
    localparam logic [AW-1:0] MAX_TRIES = AW'(PROBE_ATTEMPTS);

    rdcfg_fes_t    code_d;
    logic [TW-1:0] timer;
    logic [AW-1:0] tries;
    logic          detected;
    logic          stopped;
    logic          term_50;
    logic          probe;

    assign sif.term_50 = term_50;
    assign sif.probe   = probe;

    always_ff @(posedge clk) begin
        if (rst) begin
            code_d   <= FES_HIZ;
            timer    <= '0;
            tries    <= '0;
            detected <= 1'b0;
            stopped  <= 1'b0;
            term_50  <= 1'b0;
            probe    <= 1'b0;
        end else begin
            probe  <= 1'b0;
            code_d <= sif.code;
            if (sif.code != code_d) begin
                // Mode change restarts the search
                timer    <= '0;
                tries    <= '0;
                detected <= 1'b0;
                stopped  <= 1'b0;
                term_50  <= 1'b0;
            end else begin
                unique case (sif.code)
                    FES_HIZ:     term_50 <= 1'b0;
                    FES_TERM_50: term_50 <= 1'b1;
                    FES_AUTO_LIMITED, FES_AUTO_ENDLESS: begin
                        if (!detected && !stopped) begin
                            if (timer == LAST_TICK) begin
                                timer <= '0;
                                // Result of the previous probe is judged at the next tick
                                if (sif.rx_present && tries != '0) begin
                                    detected <= 1'b1;
                                    term_50  <= 1'b1;
                                end else if (sif.code == FES_AUTO_ENDLESS || tries != MAX_TRIES) begin
                                    probe <= 1'b1;
                                    if (sif.code == FES_AUTO_LIMITED) begin
                                        tries <= tries + 1'b1;
                                    end else begin
                                        tries <= AW'(1);
                                    end
                                end else begin
                                    // Limit reached and last probe judged
                                    stopped <= 1'b1;
                                end
                            end else begin
                                timer <= timer + 1'b1;
                            end
                        end
                    end
                endcase
            end
        end
    end

endmodule : rdcfg_sense

//--- logic/rdcfg_regs.sv
// SMBus slave register bank for the lane configuration slice
`timescale 1ns/1ns
`include "rdcfg_map.svh"
module rdcfg_regs #(
    parameter logic [6:0]  DEV_ADDR         = `RDCFG_DEV_ADDR, // Arbitrary value
    parameter int unsigned PROBE_PERIOD_CYC = `RDCFG_PROBE_PERIOD_CYC,
    parameter int unsigned PROBE_ATTEMPTS   = `RDCFG_PROBE_ATTEMPTS
) (
    input  wire logic            CLK,
    input  wire logic            RST,
    input  wire logic            SCL,
    input  wire logic            SDA_IN,
    output logic                 SDA_OUT,
    output logic                 SDA_OE,
    input  wire logic [7:0]      LANE_SIGNAL_LOSS,
    input  wire logic            SPARE_STRAP_FLOAT,
    input  wire logic [1:0]      FAR_END_SENSE_PIN,
    input  wire logic            FAR_END_SENSE_OVERRIDE,
    input  wire logic            LANE_B0_RX_PRESENT,
    output logic                 LANE_B0_PROBE,
    output logic                 LANE_B0_TERM_50,
    output logic [7:0]           BOOST_SETTING,
    output logic                 SHORT_PROTECT_EN,
    output rdcfg_pkg::rdcfg_swing_t OUTPUT_SWING
);
    import rdcfg_pkg::*;

    localparam int NPIN = 14;
    localparam logic [NPIN-1:0] PIN_IDLE = 14'h0003;

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1;
    logic [NPIN-1:0] sync2;
    logic [NPIN-1:0] sync3;
    logic [NPIN-1:0] pin_f;
    logic            scl_d;
    logic            sda_d;
    logic            scl;
    logic            sda;
    logic            start_cond;
    logic            stop_cond;
    logic            scl_rise;
    logic            scl_fall;

    rdcfg_state_t    state;
    logic [3:0]      bit_cnt;
    logic [7:0]      shreg;
    logic [7:0]      ptr;
    logic            rw;
    logic            sda_oe;
    logic            wr_stb;
    logic [7:0]      wr_addr;
    logic [7:0]      wr_data;
    logic [7:0]      rd_now;
    logic [7:0]      rd_next;

    logic [7:0]      spare_cfg_a;
    logic [7:0]      lane_signal_presence;
    logic [7:0]      spare_cfg_b;
    logic [7:0]      spare_cfg_c;
    logic [7:0]      spare_cfg_d;
    logic [7:0]      lane_b0_termination;
    logic [7:0]      lane_b0_boost;
    logic [7:0]      lane_b0_output_ctrl;

    rdcfg_sense_if   sense_if ();

    function automatic logic [7:0] read_reg(input logic [7:0] a);
        logic [7:0] d;
        d = `RDCFG_RST_UNMAPPED;
        case (a)
            `RDCFG_OFS_SPARE_A:     d = spare_cfg_a;
            `RDCFG_OFS_PRESENCE:    d = lane_signal_presence;
            `RDCFG_OFS_SPARE_B:     d = spare_cfg_b;
            `RDCFG_OFS_SPARE_C:     d = spare_cfg_c;
            `RDCFG_OFS_SPARE_D:     d = spare_cfg_d;
            `RDCFG_OFS_TERMINATION: d = lane_b0_termination;
            `RDCFG_OFS_BOOST:       d = lane_b0_boost;
            `RDCFG_OFS_OUTPUT_CTRL: d = lane_b0_output_ctrl;
            default:                d = `RDCFG_RST_UNMAPPED;
        endcase
        return d;
    endfunction : read_reg

    // Pin synchronisers, a bit changes once stages two and three agree
    assign pin_raw = {LANE_B0_RX_PRESENT, FAR_END_SENSE_PIN, SPARE_STRAP_FLOAT, LANE_SIGNAL_LOSS, SDA_IN, SCL};

    always_ff @(posedge CLK) begin
        if (RST) begin
            sync1 <= PIN_IDLE;
            sync2 <= PIN_IDLE;
            sync3 <= PIN_IDLE;
            pin_f <= PIN_IDLE;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
            pin_f <= (pin_f & (sync2 ^ sync3)) | (sync3 & ~(sync2 ^ sync3));
            scl_d <= pin_f[0];
            sda_d <= pin_f[1];
        end
    end

    assign scl        = pin_f[0];
    assign sda        = pin_f[1];
    assign start_cond = scl & scl_d & sda_d & ~sda;
    assign stop_cond  = scl & scl_d & ~sda_d & sda;
    assign scl_rise   = scl & ~scl_d;
    assign scl_fall   = ~scl & scl_d;

    // Process form, so a register change re-reads the mapped value
    always_comb begin
        rd_now  = read_reg(ptr);
        rd_next = read_reg(ptr + 8'h01);
    end

    // SMBus byte engine
    always_ff @(posedge CLK) begin
        if (RST) begin
            state   <= ST_IDLE;
            bit_cnt <= 4'h0;
            shreg   <= 8'h00;
            ptr     <= 8'h00;
            rw      <= 1'b0;
            sda_oe  <= 1'b0;
            wr_stb  <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end else begin
            wr_stb <= 1'b0;
            if (stop_cond) begin
                state  <= ST_IDLE;
                sda_oe <= 1'b0;
            end else if (start_cond) begin
                state   <= ST_ADDR;
                bit_cnt <= 4'h0;
                sda_oe  <= 1'b0;
            end else if (scl_rise) begin
                unique case (state)
                    ST_ADDR, ST_CMD, ST_WDATA: begin
                        shreg   <= {shreg[6:0], sda};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    ST_RACK: begin
                        if (sda) begin
                            state <= ST_IDLE;
                        end
                    end
                    ST_IDLE, ST_AACK, ST_CACK, ST_WACK, ST_RDATA: begin
                    end
                endcase
            end else if (scl_fall) begin
                unique case (state)
                    ST_ADDR: begin
                        if (bit_cnt == 4'h8) begin
                            if (shreg[7:1] == DEV_ADDR) begin
                                rw     <= shreg[0];
                                sda_oe <= 1'b1;
                                state  <= ST_AACK;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_CMD: begin
                        if (bit_cnt == 4'h8) begin
                            ptr    <= shreg;
                            sda_oe <= 1'b1;
                            state  <= ST_CACK;
                        end
                    end
                    ST_WDATA: begin
                        if (bit_cnt == 4'h8) begin
                            wr_stb  <= 1'b1;
                            wr_addr <= ptr;
                            wr_data <= shreg;
                            ptr     <= ptr + 8'h01;
                            sda_oe  <= 1'b1;
                            state   <= ST_WACK;
                        end
                    end
                    ST_AACK: begin
                        bit_cnt <= 4'h0;
                        if (rw) begin
                            shreg  <= rd_now;
                            sda_oe <= ~rd_now[7];
                            state  <= ST_RDATA;
                        end else begin
                            sda_oe <= 1'b0;
                            state  <= ST_CMD;
                        end
                    end
                    ST_CACK, ST_WACK: begin
                        sda_oe  <= 1'b0;
                        bit_cnt <= 4'h0;
                        state   <= ST_WDATA;
                    end
                    ST_RDATA: begin
                        if (bit_cnt == 4'h7) begin
                            sda_oe <= 1'b0;
                            state  <= ST_RACK;
                        end else begin
                            bit_cnt <= bit_cnt + 4'h1;
                            shreg   <= {shreg[6:0], 1'b0};
                            sda_oe  <= ~shreg[6];
                        end
                    end
                    ST_RACK: begin
                        ptr     <= ptr + 8'h01;
                        shreg   <= rd_next;
                        sda_oe  <= ~rd_next[7];
                        bit_cnt <= 4'h0;
                        state   <= ST_RDATA;
                    end
                    ST_IDLE: begin
                    end
                endcase
            end
        end
    end

    // Writable registers; spare ones keep what the host writes
    always_ff @(posedge CLK) begin
        if (RST) begin
            spare_cfg_a         <= `RDCFG_RST_SPARE_A;
            spare_cfg_b         <= `RDCFG_RST_SPARE_B;
            spare_cfg_c         <= `RDCFG_RST_SPARE_C;
            spare_cfg_d         <= `RDCFG_RST_SPARE_D;
            lane_b0_termination <= `RDCFG_RST_TERMINATION;
            lane_b0_boost       <= `RDCFG_RST_BOOST;
            lane_b0_output_ctrl <= `RDCFG_RST_OUTPUT_CTRL;
        end else if (wr_stb) begin
            case (wr_addr)
                `RDCFG_OFS_SPARE_A:     spare_cfg_a         <= wr_data;
                `RDCFG_OFS_SPARE_B:     spare_cfg_b         <= wr_data;
                `RDCFG_OFS_SPARE_C:     spare_cfg_c         <= wr_data;
                `RDCFG_OFS_SPARE_D:     spare_cfg_d         <= wr_data;
                `RDCFG_OFS_TERMINATION: lane_b0_termination <= wr_data;
                `RDCFG_OFS_BOOST:       lane_b0_boost       <= wr_data;
                `RDCFG_OFS_OUTPUT_CTRL: lane_b0_output_ctrl <= wr_data;
                default: begin
                end
            endcase
        end
    end

    // Presence monitor follows the lanes only while the strap floats
    always_ff @(posedge CLK) begin
        if (RST) begin
            lane_signal_presence <= `RDCFG_RST_PRESENCE;
        end else if (pin_f[10]) begin
            lane_signal_presence <= pin_f[9:2];
        end
    end

    // Override selects register field over strap pin
    assign sense_if.code = rdcfg_fes_t'(FAR_END_SENSE_OVERRIDE ?
        lane_b0_termination[`RDCFG_FES_MSB:`RDCFG_FES_LSB] : pin_f[12:11]);
    assign sense_if.rx_present = pin_f[13];

    rdcfg_sense #(
        .PROBE_PERIOD_CYC (PROBE_PERIOD_CYC),
        .PROBE_ATTEMPTS   (PROBE_ATTEMPTS)
    ) u_sense (
        .clk (CLK),
        .rst (RST),
        .sif (sense_if.engine)
    );

    always_ff @(posedge CLK) begin
        if (RST) begin
            SDA_OUT <= 1'b0;
        end else begin
            SDA_OUT <= 1'b0;
        end
    end

    assign SDA_OE           = sda_oe;
    assign LANE_B0_PROBE    = sense_if.probe;
    assign LANE_B0_TERM_50  = sense_if.term_50;
    assign BOOST_SETTING    = lane_b0_boost;
    assign SHORT_PROTECT_EN = lane_b0_output_ctrl[`RDCFG_SHORT_PROT_BIT];
    assign OUTPUT_SWING     = lane_b0_output_ctrl[`RDCFG_SWING_MSB:`RDCFG_SWING_LSB];

endmodule : rdcfg_regs

//--- tb/rdcfg_chk.sv
// Port assertions for the lane configuration register bank
`timescale 1ns/1ns
module rdcfg_chk #(
    parameter int unsigned PROBE_PERIOD_CYC = 20
) (
    input wire logic                    CLK,
    input wire logic                    RST,
    input wire logic                    SCL,
    input wire logic                    SDA_OE,
    input wire logic [1:0]              FAR_END_SENSE_PIN,
    input wire logic                    FAR_END_SENSE_OVERRIDE,
    input wire logic                    LANE_B0_PROBE,
    input wire logic                    LANE_B0_TERM_50,
    input wire logic [7:0]              BOOST_SETTING,
    input wire logic                    SHORT_PROTECT_EN,
    input wire rdcfg_pkg::rdcfg_swing_t OUTPUT_SWING
);
    import rdcfg_pkg::*;
    int unsigned gap;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    // Cycles since the last probe pulse, saturating
    always_ff @(posedge CLK) begin
        if (RST || LANE_B0_PROBE) begin
            gap <= 0;
        end else if (gap != 32'hFFFFFFFF) begin
            gap <= gap + 1;
        end
    end
    sequence s_pin_hiz;
        (!FAR_END_SENSE_OVERRIDE && FAR_END_SENSE_PIN == 2'h0) [*8];
    endsequence
    sequence s_pin_term;
        (!FAR_END_SENSE_OVERRIDE && FAR_END_SENSE_PIN == 2'h3) [*8];
    endsequence
    a_reset_values: assert property (
        $past(RST) |-> BOOST_SETTING == 8'h2F && SHORT_PROTECT_EN && OUTPUT_SWING == 3'h5 && !LANE_B0_TERM_50)
        else $error("outputs not at reset values");
    a_probe_pulse: assert property (
        LANE_B0_PROBE |=> !LANE_B0_PROBE) else $error("probe pulse too long");
    a_probe_spacing: assert property (
        LANE_B0_PROBE |-> gap >= PROBE_PERIOD_CYC - 1) else $error("probes too close");
    a_term_stops_probe: assert property (
        LANE_B0_TERM_50 |-> !LANE_B0_PROBE) else $error("probe while terminated");
    a_pin_hiz: assert property (
        s_pin_hiz |=> !LANE_B0_TERM_50 && !LANE_B0_PROBE) else $error("pin code 00 not high impedance");
    a_pin_term: assert property (
        s_pin_term |=> LANE_B0_TERM_50 && !LANE_B0_PROBE) else $error("pin code 11 not terminated");
    a_boost_scl_low: assert property (
        $changed(BOOST_SETTING) |-> !SCL) else $error("boost changed outside a write");
    a_outctl_scl_low: assert property (
        $changed(SHORT_PROTECT_EN) || $changed(OUTPUT_SWING) |-> !SCL) else $error("output control changed oddly");
    a_ack_scl_low: assert property (
        $rose(SDA_OE) |-> !SCL) else $error("data line pulled while clock high");
endmodule : rdcfg_chk
bind rdcfg_regs rdcfg_chk #(.PROBE_PERIOD_CYC(PROBE_PERIOD_CYC)) u_chk (
    .CLK(CLK), .RST(RST), .SCL(SCL), .SDA_OE(SDA_OE), .FAR_END_SENSE_PIN(FAR_END_SENSE_PIN),
    .FAR_END_SENSE_OVERRIDE(FAR_END_SENSE_OVERRIDE), .LANE_B0_PROBE(LANE_B0_PROBE),
    .LANE_B0_TERM_50(LANE_B0_TERM_50), .BOOST_SETTING(BOOST_SETTING),
    .SHORT_PROTECT_EN(SHORT_PROTECT_EN), .OUTPUT_SWING(OUTPUT_SWING));

//--- tb/rdcfg_host.sv
// SMBus host model reaching the register bank over its serial port
`timescale 1ns/1ns
module rdcfg_host #(
    parameter logic [6:0] DEV_ADDR = 7'h5A,
    parameter int         HALF     = 12
) (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_oe
);
    initial begin
        scl = 1'h1;
        sda_oe = 1'h0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_n
    // Data moves mid low phase, sampled late in the high phase
    task automatic bit_io(input logic b, output logic r);
        wait_n(HALF / 2);
        sda_oe = ~b;
        wait_n(HALF / 2);
        scl = 1'h1;
        wait_n(HALF);
        r = sda;
        scl = 1'h0;
    endtask : bit_io
    task automatic start_cond();
        if (scl === 1'h0) begin
            wait_n(HALF / 2);
            sda_oe = 1'h0;
            wait_n(HALF / 2);
            scl = 1'h1;
        end
        wait_n(HALF);
        sda_oe = 1'h1;
        wait_n(HALF);
        scl = 1'h0;
    endtask : start_cond
    task automatic stop_cond();
        wait_n(HALF / 2);
        sda_oe = 1'h1;
        wait_n(HALF / 2);
        scl = 1'h1;
        wait_n(HALF);
        sda_oe = 1'h0;
        wait_n(HALF);
    endtask : stop_cond
    // Ack slot released: slave ack on writes, host nack on reads
    task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic nak);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(1'h1, nak);
    endtask : byte_io
    task automatic xfer(input logic rd, input logic [7:0] ofs, input logic [7:0] wd,
                        output logic [7:0] rdat, output logic ok);
        logic [7:0] r;
        logic       n0, n1, n2;
        start_cond();
        byte_io({DEV_ADDR, 1'h0}, r, n0);
        byte_io(ofs, r, n1);
        if (rd) begin
            start_cond();
            byte_io({DEV_ADDR, 1'h1}, r, n2);
            byte_io(8'hFF, rdat, r[0]);
        end else begin
            byte_io(wd, rdat, n2);
        end
        stop_cond();
        ok = ~(n0 | n1 | n2);
    endtask : xfer
endmodule : rdcfg_host

//--- tb/tb_top.sv
// Self-checking bench for the lane configuration register bank
`timescale 1ns/1ns
`include "rdcfg_map.svh"
module tb_top;
    import rdcfg_pkg::*;
    localparam int PER   = 20;
    localparam int ATT   = 3;
    localparam int LIMIT = 80000;
    logic         clk, rst, scl, host_oe, sda_oe, sda_out, strap, ovr, rx, probe, term, prot;
    logic [7:0]   loss, boost;
    logic [1:0]   pin;
    rdcfg_swing_t swing;
    int           n_fail, num_checks, cyc, n_probe;
    wire logic    sda = ~host_oe & (~sda_oe | sda_out);
    rdcfg_regs #(.PROBE_PERIOD_CYC(PER), .PROBE_ATTEMPTS(ATT)) dut (
        .CLK(clk), .RST(rst), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
        .LANE_SIGNAL_LOSS(loss), .SPARE_STRAP_FLOAT(strap), .FAR_END_SENSE_PIN(pin),
        .FAR_END_SENSE_OVERRIDE(ovr), .LANE_B0_RX_PRESENT(rx), .LANE_B0_PROBE(probe),
        .LANE_B0_TERM_50(term), .BOOST_SETTING(boost), .SHORT_PROTECT_EN(prot), .OUTPUT_SWING(swing));
    rdcfg_host #(.DEV_ADDR(`RDCFG_DEV_ADDR)) host (.clk(clk), .sda(sda), .scl(scl), .sda_oe(host_oe));
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (probe === 1'h1) n_probe++;
        if (cyc == LIMIT) begin
            n_fail++;
            report_and_stop();
        end
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_n
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic chk_n(input string nm, input int exp, input int got);
        num_checks++;
        if (got != exp) begin
            n_fail++;
            $display("MISMATCH %s expected %0d seen %0d", nm, exp, got);
        end
    endtask : chk_n
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic       ok;
        host.xfer(1'h0, a, d, r, ok);
        chk("write ack", 8'h01, {7'h00, ok});
    endtask : wr
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        host.xfer(1'h1, a, 8'h00, d, ok);
        chk(nm, exp, d);
    endtask : rd_chk
    task automatic t_reset();
        rd_chk("spare_cfg_a", `RDCFG_OFS_SPARE_A, 8'h00);
        rd_chk("lane_signal_presence", `RDCFG_OFS_PRESENCE, 8'h00);
        rd_chk("spare_cfg_b", `RDCFG_OFS_SPARE_B, 8'h70);
        rd_chk("spare_cfg_c", `RDCFG_OFS_SPARE_C, 8'h00);
        rd_chk("spare_cfg_d", `RDCFG_OFS_SPARE_D, 8'h00);
        rd_chk("lane_b0_termination", `RDCFG_OFS_TERMINATION, 8'h00);
        rd_chk("lane_b0_boost", `RDCFG_OFS_BOOST, 8'h2F);
        rd_chk("lane_b0_output_ctrl", `RDCFG_OFS_OUTPUT_CTRL, 8'hAD);
        chk("boost port", 8'h2F, boost);
        chk("protect port", 8'h01, {7'h00, prot});
        chk("swing port", 8'h05, {5'h00, swing});
    endtask : t_reset
    task automatic t_rw();
        logic [7:0] v;
        wr(8'h06, 8'h18);
        rd_chk("unmapped", 8'h06, 8'h00);
        wr(`RDCFG_OFS_BOOST, 8'h33);
        chk("boost port", 8'h33, boost);
        rd_chk("lane_b0_boost", `RDCFG_OFS_BOOST, 8'h33);
        for (int s = 0; s < 8; s++) begin
            v = {s[0], 4'h5, s[2:0]};
            wr(`RDCFG_OFS_OUTPUT_CTRL, v);
            chk("protect port", {7'h00, v[7]}, {7'h00, prot});
            chk("swing port", {5'h00, v[2:0]}, {5'h00, swing});
            rd_chk("lane_b0_output_ctrl", `RDCFG_OFS_OUTPUT_CTRL, v);
        end
        wr(`RDCFG_OFS_SPARE_B, 8'h70);
        rd_chk("spare_cfg_b", `RDCFG_OFS_SPARE_B, 8'h70);
    endtask : t_rw
    task automatic t_monitor();
        strap = 1'h1;
        loss = 8'hA5;
        rd_chk("presence", `RDCFG_OFS_PRESENCE, 8'hA5);
        wr(`RDCFG_OFS_PRESENCE, 8'h00);
        rd_chk("presence kept", `RDCFG_OFS_PRESENCE, 8'hA5);
        strap = 1'h0;
        loss = 8'h3C;
        rd_chk("presence held", `RDCFG_OFS_PRESENCE, 8'hA5);
        strap = 1'h1;
        rd_chk("presence new", `RDCFG_OFS_PRESENCE, 8'h3C);
    endtask : t_monitor
    // Stage a sense code under pin control, then hand control to the register
    task automatic enter(input logic [7:0] v, input logic rxv, input int n);
        ovr = 1'h0;
        wr(`RDCFG_OFS_TERMINATION, v);
        rx = rxv;
        n_probe = 0;
        ovr = 1'h1;
        wait_n(n);
    endtask : enter
    task automatic t_sense();
        pin = 2'h3;
        wait_n(12);
        chk("term by pin", 8'h01, {7'h00, term});
        wr(`RDCFG_OFS_TERMINATION, 8'h00);
        chk("term pin kept", 8'h01, {7'h00, term});
        ovr = 1'h1;
        wait_n(4);
        chk("term code 00", 8'h00, {7'h00, term});
        pin = 2'h0;
        enter(8'h0C, 1'h0, 4);
        chk("term code 11", 8'h01, {7'h00, term});
        enter(8'h04, 1'h0, PER * (ATT + 3));
        chk_n("limited probes", ATT, n_probe);
        chk("term no receiver", 8'h00, {7'h00, term});
        rx = 1'h1;
        wait_n(PER * 2 + 8);
        chk("term after limit", 8'h00, {7'h00, term});
        chk_n("probes after limit", ATT, n_probe);
        enter(8'h08, 1'h0, PER * (ATT + 4) + PER / 2);
        chk("endless probing", 8'h01, {7'h00, n_probe > ATT});
        rx = 1'h1;
        wait_n(PER * 2 + 8);
        chk("term on detect", 8'h01, {7'h00, term});
        n_probe = 0;
        wait_n(PER * 3);
        chk_n("probes after detect", 0, n_probe);
        enter(8'h04, 1'h1, PER * 2 + 8);
        chk("limited detect", 8'h01, {7'h00, term});
        chk_n("probes to detect", 1, n_probe);
    endtask : t_sense
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        rst = 1'h1;
        strap = 1'h0;
        ovr = 1'h0;
        rx = 1'h0;
        loss = 8'h00;
        pin = 2'h0;
        wait_n(6);
        rst = 1'h0;
        wait_n(8);
        t_reset();
        t_rw();
        t_monitor();
        t_sense();
        strap = 1'h0;
        rst = 1'h1;
        wait_n(6);
        rst = 1'h0;
        wait_n(8);
        t_reset();
        report_and_stop();
    end
endmodule : tb_top
